//--- core/bts_pkg.sv
// Shared constants and types for the bit-test-and-skip execute block
package bts_pkg;

  // Instruction word fields
  localparam logic [3:0] OPC_SKIP_CLEAR = 4'hb;
  localparam logic [3:0] OPC_SKIP_SET = 4'ha;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int BANK_FLAG_POS = 8;
  localparam int FILE_MSB = 7;
  localparam int FILE_LSB = 0;

  // Data addressing
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // Instruction cycle costs
  localparam logic [1:0] CYCLES_PLAIN = 2'h1;
  localparam logic [1:0] CYCLES_SKIP = 2'h2;
  localparam logic [1:0] CYCLES_SKIP_LONG = 2'h3;

  // Values after reset
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [2:0] BIT_RESET = 3'h0;
  localparam logic [1:0] COUNT_RESET = 2'h0;

  // Four clock phases make one instruction cycle
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } bts_phase_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TEST = 2'b01,
    ST_FLUSH = 2'b10
  } bts_state_e;

endpackage

//--- core/bts_addr_resolve.sv
// Operand address resolution from bank flag, bank select and file field
`timescale 1ns/10ps
module bts_addr_resolve (
  // Decoded fields
  input wire logic bank_flag_in,
  input wire logic [7:0] file_addr_in,
  // Addressing context
  input wire logic [3:0] bank_select_in,
  input wire logic ext_set_en_in,
  input wire logic [11:0] index_base_in,
  // Result
  output logic [11:0] data_addr_out,
  output logic indexed_out
);
  import bts_pkg::*;

  always_comb begin
    indexed_out = !bank_flag_in && ext_set_en_in && (file_addr_in <= INDEX_LIMIT);
    if (bank_flag_in) begin
      data_addr_out = {bank_select_in, file_addr_in};
    end else if (indexed_out) begin
      // Wraps within the 12-bit data space
      data_addr_out = index_base_in + {4'h0, file_addr_in};
    end else if (file_addr_in <= INDEX_LIMIT) begin
      data_addr_out = {ACCESS_LOW_BANK, file_addr_in};
    end else begin
      data_addr_out = {ACCESS_HIGH_BANK, file_addr_in};
    end
  end

endmodule

//--- core/bts_exec.sv
// Decode and execute of the two bit-test-and-skip instructions
`timescale 1ns/10ps
module bts_exec (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Instruction issue, sampled in Q1; next_two_word_in is sampled in Q4 of the test cycle
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic next_two_word_in,
  // Addressing context
  input wire logic [3:0] bank_select_in,
  input wire logic ext_set_en_in,
  input wire logic [11:0] index_base_in,
  // Data read, sampled in Q3
  input wire logic [7:0] data_rd_in,
  // Phase and data port
  output bts_pkg::bts_phase_e phase_out,
  output logic [11:0] data_addr_out,
  output logic data_rd_en_out,
  output logic indexed_out,
  // Execution status
  output logic decode_hit_out,
  output logic skip_out,
  output logic nop_cycle_out,
  output logic reg_write_out,
  output logic status_write_out
);
  import bts_pkg::*;

  bts_phase_e phase;
  bts_phase_e next_phase;
  bts_state_e state;
  bts_state_e next_state;
  logic test_clear;
  logic next_test_clear;
  logic [2:0] bit_sel;
  logic [2:0] next_bit_sel;
  logic take;
  logic next_take;
  logic [1:0] nop_left;
  logic [1:0] next_nop_left;
  logic [11:0] next_data_addr;
  logic next_data_rd_en;
  logic next_indexed;
  logic next_decode_hit;
  logic next_skip;
  logic next_nop_cycle;
  logic [11:0] resolved_addr;
  logic resolved_indexed;
  logic [3:0] opcode;
  logic hit;

  assign opcode = instr_word_in[OPC_MSB:OPC_LSB];
  assign hit = (opcode == OPC_SKIP_CLEAR) || (opcode == OPC_SKIP_SET);

  bts_addr_resolve u_addr (
    .bank_flag_in(instr_word_in[BANK_FLAG_POS]),
    .file_addr_in(instr_word_in[FILE_MSB:FILE_LSB]),
    .bank_select_in(bank_select_in),
    .ext_set_en_in(ext_set_en_in),
    .index_base_in(index_base_in),
    .data_addr_out(resolved_addr),
    .indexed_out(resolved_indexed)
  );

  // Phase counter: free running, one instruction cycle per four clocks
  always_comb begin
    next_phase = bts_phase_e'(phase + 2'h1);
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase <= Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    next_test_clear = test_clear;
    next_bit_sel = bit_sel;
    next_take = take;
    next_nop_left = nop_left;
    next_data_addr = data_addr_out;
    next_data_rd_en = data_rd_en_out;
    next_indexed = indexed_out;
    next_decode_hit = decode_hit_out;
    next_skip = 1'b0;
    next_nop_cycle = nop_cycle_out;
    unique case (state)
      ST_IDLE: begin
        if (phase == Q1 && instr_valid_in && hit) begin
          next_state = ST_TEST;
          next_test_clear = (opcode == OPC_SKIP_CLEAR);
          next_bit_sel = instr_word_in[BIT_MSB:BIT_LSB];
          next_data_addr = resolved_addr;
          next_indexed = resolved_indexed;
          next_data_rd_en = 1'b1;
          next_decode_hit = 1'b1;
        end
      end
      ST_TEST: begin
        if (phase == Q3) begin
          next_take = test_clear ? !data_rd_in[bit_sel] : data_rd_in[bit_sel];
          next_data_rd_en = 1'b0;
        end else if (phase == Q4) begin
          next_decode_hit = 1'b0;
          next_take = 1'b0;
          if (take) begin
            next_state = ST_FLUSH;
            next_skip = 1'b1;
            next_nop_cycle = 1'b1;
            next_nop_left = next_two_word_in ? (CYCLES_SKIP_LONG - CYCLES_PLAIN)
                                             : (CYCLES_SKIP - CYCLES_PLAIN);
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_FLUSH: begin
        // Words issued now are the discarded prefetch and are not decoded
        if (phase == Q4) begin
          next_nop_left = nop_left - 2'h1;
          if (nop_left == CYCLES_PLAIN) begin
            next_state = ST_IDLE;
            next_nop_cycle = 1'b0;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_nop_cycle = 1'b0;
        next_decode_hit = 1'b0;
        next_data_rd_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      test_clear <= 1'b0;
      bit_sel <= BIT_RESET;
      take <= 1'b0;
      nop_left <= COUNT_RESET;
      data_addr_out <= ADDR_RESET;
      data_rd_en_out <= 1'b0;
      indexed_out <= 1'b0;
      decode_hit_out <= 1'b0;
      skip_out <= 1'b0;
      nop_cycle_out <= 1'b0;
    end else begin
      state <= next_state;
      test_clear <= next_test_clear;
      bit_sel <= next_bit_sel;
      take <= next_take;
      nop_left <= next_nop_left;
      data_addr_out <= next_data_addr;
      data_rd_en_out <= next_data_rd_en;
      indexed_out <= next_indexed;
      decode_hit_out <= next_decode_hit;
      skip_out <= next_skip;
      nop_cycle_out <= next_nop_cycle;
    end
  end

  // The test is read-only; the write strobes exist so the core can merge them
  // never write back
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_write_out <= 1'b0;
      status_write_out <= 1'b0;
    end else begin
      reg_write_out <= 1'b0;
      status_write_out <= 1'b0;
    end
  end

  assign phase_out = phase;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  logic issue_q1;
  assign issue_q1 = (phase == Q1) && (state == ST_IDLE) && instr_valid_in;

  sequence seq_short_flush;
    nop_cycle_out [*4] ##1 !nop_cycle_out;
  endsequence

  sequence seq_long_flush;
    nop_cycle_out [*8] ##1 !nop_cycle_out;
  endsequence

  decode_clear_a: assert property (
    issue_q1 && opcode == OPC_SKIP_CLEAR |=> decode_hit_out && test_clear
      && bit_sel == $past(instr_word_in[BIT_MSB:BIT_LSB]))
    else $error("skip-if-clear word not decoded");

  decode_set_a: assert property (
    issue_q1 && opcode == OPC_SKIP_SET |=> decode_hit_out && !test_clear)
    else $error("skip-if-set word not decoded");

  skip_clear_a: assert property (
    state == ST_TEST && phase == Q3 && test_clear && !data_rd_in[bit_sel]
      |-> ##2 skip_out)
    else $error("clear bit did not skip");

  skip_set_a: assert property (
    state == ST_TEST && phase == Q3 && !test_clear
      |-> ##2 (skip_out == $past(data_rd_in[bit_sel], 2)))
    else $error("set variant skip decision wrong");

  short_flush_a: assert property (
    $rose(skip_out) && !$past(next_two_word_in) |-> seq_short_flush)
    else $error("single no-op cycle length wrong");

  long_flush_a: assert property (
    $rose(skip_out) && $past(next_two_word_in) |-> seq_long_flush)
    else $error("two-word skip length wrong");

  flush_ignore_a: assert property (
    state == ST_FLUSH && phase == Q1 |=> !decode_hit_out)
    else $error("flushed word was decoded");

  bank_addr_a: assert property (
    issue_q1 && hit && instr_word_in[BANK_FLAG_POS] |=> data_rd_en_out
      && data_addr_out == {$past(bank_select_in), $past(instr_word_in[FILE_MSB:FILE_LSB])})
    else $error("banked address wrong");

  indexed_addr_a: assert property (
    issue_q1 && hit && !instr_word_in[BANK_FLAG_POS] && ext_set_en_in
      && instr_word_in[FILE_MSB:FILE_LSB] <= INDEX_LIMIT |=> indexed_out
      && data_addr_out == $past(index_base_in) + {4'h0, $past(instr_word_in[FILE_MSB:FILE_LSB])})
    else $error("indexed offset address wrong");

  no_write_a: assert property (
    decode_hit_out |-> !reg_write_out && !status_write_out)
    else $error("bit test wrote state");

endmodule

//--- verification/bts_exec_tb.sv
// Self-checking testbench for the bit-test-and-skip execute block
`timescale 1ns/10ps
module bts_exec_tb;
  import bts_pkg::*;
  typedef struct {logic skip; logic long_skip; logic [11:0] addr; logic indexed;} bts_note_s;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic next_two_word_in = 1'b0;
  logic ext_set_en_in = 1'b0;
  logic [15:0] instr_word_in = 16'h0000;
  logic [3:0] bank_select_in = 4'h0;
  logic [11:0] index_base_in = 12'h000;
  logic [7:0] data_rd_in = 8'h00;
  bts_phase_e phase_out;
  logic [11:0] data_addr_out;
  logic data_rd_en_out, indexed_out, decode_hit_out, skip_out, nop_cycle_out;
  logic reg_write_out, status_write_out;
  int fail_count = 0;
  int compares = 0;
  int nop_len = 0;
  bts_note_s notes[$];
  bts_note_s pend;
  logic [31:0] rng = 32'h1b91da6a;
  logic hit_prev = 1'b0;
  logic last_skip = 1'b0;

  bts_exec uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in), .next_two_word_in(next_two_word_in),
    .bank_select_in(bank_select_in), .ext_set_en_in(ext_set_en_in),
    .index_base_in(index_base_in), .data_rd_in(data_rd_in), .phase_out(phase_out),
    .data_addr_out(data_addr_out), .data_rd_en_out(data_rd_en_out), .indexed_out(indexed_out),
    .decode_hit_out(decode_hit_out), .skip_out(skip_out), .nop_cycle_out(nop_cycle_out),
    .reg_write_out(reg_write_out), .status_write_out(status_write_out));

  always #2 ref_clk_in = ~ref_clk_in;

  function logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task chk_addr(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task chk_flag(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task give_verdict();
    $display("counts: compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Issue one word at a Q1 edge; the expected outcome is noted when push is set
  task issue(input logic [15:0] w, input logic ext, input logic b2b, input logic push);
    int n;
    bts_note_s e;
    logic [31:0] r;
    logic [7:0] f;
    logic [3:0] bank_select_register;
    logic [11:0] base;
    logic two;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (!(phase_out === Q4 && (b2b || (decode_hit_out === 1'b0 &&
               nop_cycle_out === 1'b0))) && n < 64);
    if (n >= 64) begin
      fail_count++;
      $display("mismatch at %0t: no issue slot", $time);
      give_verdict();
    end
    r = xs();
    f = w[FILE_MSB:FILE_LSB];
    bank_select_register = r[3:0];
    base = r[15:4];
    two = r[16];
    e.skip = r[24 + w[BIT_MSB:BIT_LSB]] ^ (w[OPC_MSB:OPC_LSB] == OPC_SKIP_CLEAR);
    e.long_skip = two;
    e.indexed = 1'b0;
    if (w[BANK_FLAG_POS])
      e.addr = {bank_select_register, f};
    else if (ext && f <= INDEX_LIMIT) begin
      e.addr = base + 12'(f);
      e.indexed = 1'b1;
    end else
      e.addr = {(f <= INDEX_LIMIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b1;
    instr_word_in <= w;
    ext_set_en_in <= ext;
    bank_select_in <= bank_select_register;
    index_base_in <= base;
    next_two_word_in <= two;
    data_rd_in <= r[31:24];
    if (push)
      notes.push_back(e);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    last_skip = push & e.skip;
  endtask

  // Monitor: each decode takes the oldest note
  always @(negedge ref_clk_in) begin
    if (!reset_in) begin
      if (decode_hit_out === 1'b1 && hit_prev !== 1'b1) begin
        if (notes.size() == 0) begin
          fail_count++;
          $display("mismatch at %0t: decode without a valid test word", $time);
        end else begin
          pend = notes.pop_front();
          chk_addr(data_addr_out, pend.addr, "operand address");
          chk_flag(indexed_out, pend.indexed, "indexed select");
          chk_flag(data_rd_en_out, 1'b1, "read enable");
          chk_flag(phase_out === Q2, 1'b1, "decode phase");
        end
      end
      if (decode_hit_out === 1'b1) begin
        chk_flag(reg_write_out | status_write_out, 1'b0, "write strobe");
      end
      if (hit_prev === 1'b1 && decode_hit_out !== 1'b1) begin
        chk_flag(skip_out, pend.skip, "skip decision");
        if (!pend.skip)
          chk_flag(nop_cycle_out, 1'b0, "no skip cost");
      end
      if (nop_cycle_out === 1'b1) begin
        nop_len++;
        // Skip strobe lasts one clock only
        if (nop_len == 2)
          chk_flag(skip_out, 1'b0, "skip pulse length");
      end else if (nop_len > 0) begin
        if (pend.long_skip)
          chk_addr(12'(nop_len), 12'h008, "two-word no-op length");
        else
          chk_addr(12'(nop_len), 12'h004, "no-op length");
        nop_len = 0;
      end
      hit_prev = decode_hit_out;
    end
  end

  initial begin
    logic [31:0] r;
    logic was_skip;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    // Indexed window edge, then first address past it
    issue({OPC_SKIP_CLEAR, 3'h7, 1'b0, 8'h5f}, 1'b1, 1'b0, 1'b1);
    issue({OPC_SKIP_SET, 3'h0, 1'b0, 8'h60}, 1'b1, 1'b0, 1'b1);
    issue({OPC_SKIP_SET, 3'h3, 1'b0, 8'h00}, 1'b0, 1'b0, 1'b1);
    // Other opcodes must not decode
    issue(16'h5123, 1'b0, 1'b0, 1'b0);
    issue(16'hc9ff, 1'b1, 1'b0, 1'b0);
    $display("test directed done");
    for (int i = 0; i < 80; i++) begin
      r = xs();
      // The flushed word clears last_skip, so keep the skip seen before it
      was_skip = last_skip;
      if (was_skip)
        issue({OPC_SKIP_SET, r[27:16]}, r[1], 1'b1, 1'b0);
      issue({r[0] ? OPC_SKIP_SET : OPC_SKIP_CLEAR, r[15:4]}, r[1], !was_skip, 1'b1);
    end
    $display("test random done");
    repeat (20) @(posedge ref_clk_in);
    chk_addr(12'(notes.size()), 12'h000, "tests left undecoded");
    give_verdict();
  end
endmodule
